/* core/flash_self_program_control.sv */
// flash self-programming controller with register bus and cpu strobes
`timescale 1ns/10ps
module flash_self_program_control
	import flash_self_program_pkg::*;
#(
	parameter int PROG_CYCLES = PROG_CYCLES_DEFAULT
) (
	input wire logic I_CLK,
	input wire logic I_RST,
	input wire logic [31:0] I_AWADDR,
	input wire logic I_AWVALID,
	output logic O_AWREADY,
	input wire logic [31:0] I_WDATA,
	input wire logic [3:0] I_WSTRB,
	input wire logic I_WVALID,
	output logic O_WREADY,
	output logic [1:0] O_BRESP,
	output logic O_BVALID,
	input wire logic I_BREADY,
	input wire logic [31:0] I_ARADDR,
	input wire logic I_ARVALID,
	output logic O_ARREADY,
	output logic [31:0] O_RDATA,
	output logic [1:0] O_RRESP,
	output logic O_RVALID,
	input wire logic I_RREADY,
	input wire logic I_STORE_STROBE,
	input wire logic I_LOAD_STROBE,
	input wire logic [15:0] I_DATA_PAIR,
	output logic [7:0] O_LOAD_DATA,
	output logic O_LOAD_VALID,
	output logic O_CPU_HALT,
	input wire logic I_EEPROM_WRITE_BUSY,
	input wire logic [7:0] I_LOW_FUSE,
	input wire logic [7:0] I_HIGH_FUSE,
	input wire logic [7:0] I_LOCK_BITS
);

	localparam logic [19:0] PROG_LAST = 20'(PROG_CYCLES - 1);

	logic [7:0] aw_addr;
	logic aw_have;
	logic [7:0] w_data;
	logic w_strb;
	logic w_have;
	logic do_write;
	logic [4:0] cmd;
	logic [2:0] arm_age;
	logic [15:0] pointer;
	flash_op_t prog_op;
	logic [19:0] prog_cnt;
	logic [4:0] prog_page;
	logic prog_done;
	logic [15:0] page_buf [PAGE_WORDS];
	logic [PAGE_WORDS-1:0] buf_loaded;
	logic [15:0] flash_mem [FLASH_WORDS];
	logic eeprom_busy_prev;
	logic cpu_active;
	logic store_taken;
	logic load_fuse;
	logic cmd_write;
	logic [4:0] next_cmd_pattern;
	logic [7:0] read_value;
	logic read_hit;
	logic [15:0] load_word;

	////////////////////////////////////////////////////////////////////
	// register bus write side

	assign do_write = aw_have && w_have && !O_BVALID;

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			O_AWREADY <= 1'b0;
			aw_have <= 1'b0;
			aw_addr <= RESET_BYTE;
		end else if (I_AWVALID && O_AWREADY) begin
			O_AWREADY <= 1'b0;
			aw_have <= 1'b1;
			aw_addr <= I_AWADDR[7:0];
		end else if (do_write) begin
			aw_have <= 1'b0;
		end else if (!aw_have && !O_BVALID) begin
			O_AWREADY <= 1'b1;
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			O_WREADY <= 1'b0;
			w_have <= 1'b0;
			w_data <= RESET_BYTE;
			w_strb <= 1'b0;
		end else if (I_WVALID && O_WREADY) begin
			O_WREADY <= 1'b0;
			w_have <= 1'b1;
			w_data <= I_WDATA[7:0];
			w_strb <= I_WSTRB[0];
		end else if (do_write) begin
			w_have <= 1'b0;
		end else if (!w_have && !O_BVALID) begin
			O_WREADY <= 1'b1;
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			O_BVALID <= 1'b0;
			O_BRESP <= RESP_OKAY;
		end else if (do_write) begin
			O_BVALID <= 1'b1;
			if (aw_addr == OFFS_CONTROL_STATUS ||
				aw_addr == OFFS_POINTER_HIGH ||
				aw_addr == OFFS_POINTER_LOW ||
				aw_addr == OFFS_ENGINE_STATUS) begin
				O_BRESP <= RESP_OKAY;
			end else begin
				O_BRESP <= RESP_SLVERR;
			end
		end else if (I_BREADY) begin
			O_BVALID <= 1'b0;
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			pointer <= {RESET_BYTE, RESET_BYTE};
		end else if (do_write && w_strb) begin
			if (aw_addr == OFFS_POINTER_HIGH) begin
				pointer[15:8] <= w_data;
			end
			if (aw_addr == OFFS_POINTER_LOW) begin
				pointer[7:0] <= w_data;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// register bus read side

	always_comb begin
		read_hit = 1'b1;
		unique case (I_ARADDR[7:0])
			OFFS_CONTROL_STATUS: read_value = {3'h0, cmd};
			OFFS_POINTER_HIGH: read_value = pointer[15:8];
			OFFS_POINTER_LOW: read_value = pointer[7:0];
			OFFS_ENGINE_STATUS:
				read_value = {5'h00, I_EEPROM_WRITE_BUSY, prog_op};
			default: begin
				read_value = RESET_BYTE;
				read_hit = 1'b0;
			end
		endcase
	end

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			O_ARREADY <= 1'b0;
			O_RVALID <= 1'b0;
			O_RDATA <= 32'h0000_0000;
			O_RRESP <= RESP_OKAY;
		end else if (I_ARVALID && O_ARREADY) begin
			O_ARREADY <= 1'b0;
			O_RVALID <= 1'b1;
			O_RDATA <= {24'h00_0000, read_value};
			O_RRESP <= read_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (O_RVALID) begin
			if (I_RREADY) begin
				O_RVALID <= 1'b0;
			end
		end else begin
			O_ARREADY <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// command arming and windows

	assign next_cmd_pattern = w_data[4:0];
	assign cmd_write = do_write && w_strb &&
		aw_addr == OFFS_CONTROL_STATUS && prog_op == OP_IDLE &&
		!I_EEPROM_WRITE_BUSY &&
		(next_cmd_pattern == CMD_BUFFER_CLEAR ||
		next_cmd_pattern == CMD_FUSE_READ ||
		next_cmd_pattern == CMD_PAGE_WRITE ||
		next_cmd_pattern == CMD_PAGE_ERASE ||
		next_cmd_pattern == CMD_BUFFER_LOAD);
	assign cpu_active = prog_op == OP_IDLE;
	assign store_taken = I_STORE_STROBE && cpu_active &&
		cmd[BIT_ENABLE] && arm_age < STORE_WINDOW &&
		!I_EEPROM_WRITE_BUSY;
	assign load_fuse = I_LOAD_STROBE && cpu_active &&
		cmd[BIT_FUSE_READ] && arm_age < LOAD_WINDOW &&
		!I_EEPROM_WRITE_BUSY;

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			cmd <= CMD_NONE;
			arm_age <= 3'h0;
		end else if (cmd_write) begin
			cmd <= (next_cmd_pattern == CMD_BUFFER_CLEAR) ?
				CMD_NONE : next_cmd_pattern;
			arm_age <= 3'h0;
		end else if (prog_done) begin
			cmd <= CMD_NONE;
		end else if (prog_op == OP_IDLE && cmd != CMD_NONE) begin
			if (store_taken && (cmd[BIT_PAGE_WRITE] ||
				cmd[BIT_PAGE_ERASE])) begin
				// page commands hold their bits until the operation ends
				arm_age <= arm_age;
			end else if (store_taken || load_fuse) begin
				cmd <= CMD_NONE;
			end else if (cmd[BIT_FUSE_READ] &&
				arm_age == LOAD_WINDOW - 3'h1) begin
				cmd <= CMD_NONE;
			end else if (arm_age == STORE_WINDOW - 3'h1) begin
				cmd <= CMD_NONE;
			end else begin
				arm_age <= arm_age + 3'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// flash operation timer; a running operation survives reset

	assign prog_done = prog_op != OP_IDLE && prog_cnt == PROG_LAST;

	always_ff @(posedge I_CLK) begin
		if (prog_op != OP_IDLE) begin
			if (prog_done) begin
				prog_op <= OP_IDLE;
				prog_cnt <= 20'h0_0000;
			end else begin
				prog_cnt <= prog_cnt + 20'h0_0001;
			end
		end else begin
			prog_cnt <= 20'h0_0000;
			if (I_RST) begin
				prog_op <= OP_IDLE;
			end else if (store_taken && cmd[BIT_PAGE_ERASE]) begin
				prog_op <= OP_ERASE;
			end else if (store_taken && cmd[BIT_PAGE_WRITE]) begin
				prog_op <= OP_WRITE;
			end else begin
				prog_op <= OP_IDLE;
			end
		end
	end

	always_ff @(posedge I_CLK) begin
		if (prog_op == OP_IDLE && store_taken) begin
			prog_page <= pointer[PAGE_MSB:PAGE_LSB];
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			// a running operation keeps the core stalled through reset
			O_CPU_HALT <= prog_op != OP_IDLE && !prog_done;
		end else begin
			O_CPU_HALT <= (prog_op != OP_IDLE && !prog_done) ||
				(prog_op == OP_IDLE && store_taken &&
				(cmd[BIT_PAGE_ERASE] || cmd[BIT_PAGE_WRITE]));
		end
	end

	////////////////////////////////////////////////////////////////////
	// temporary page buffer

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			eeprom_busy_prev <= 1'b0;
		end else begin
			eeprom_busy_prev <= I_EEPROM_WRITE_BUSY;
		end
	end

	always_ff @(posedge I_CLK) begin
		// a page write in flight keeps its data through reset
		if (I_RST && prog_op != OP_WRITE) begin
			buf_loaded <= '0;
		end else if (prog_done && prog_op == OP_WRITE) begin
			buf_loaded <= '0;
		end else if (cmd_write && next_cmd_pattern == CMD_BUFFER_CLEAR) begin
			buf_loaded <= '0;
		end else if (I_EEPROM_WRITE_BUSY && !eeprom_busy_prev) begin
			buf_loaded <= '0;
		end else if (store_taken && cmd == CMD_BUFFER_LOAD) begin
			buf_loaded[pointer[WORD_MSB:WORD_LSB]] <= 1'b1;
		end
	end

	always_ff @(posedge I_CLK) begin
		if (store_taken && cmd == CMD_BUFFER_LOAD) begin
			page_buf[pointer[WORD_MSB:WORD_LSB]] <= I_DATA_PAIR;
		end
	end

	////////////////////////////////////////////////////////////////////
	// flash array, updated when an operation completes

	always_ff @(posedge I_CLK) begin
		if (prog_done) begin
			for (int i = 0; i < PAGE_WORDS; i++) begin
				if (prog_op == OP_ERASE) begin
					flash_mem[{prog_page, 4'(i)}] <= ERASED_WORD;
				end else begin
					flash_mem[{prog_page, 4'(i)}] <= buf_loaded[i] ?
						page_buf[i] : ERASED_WORD;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// load instruction answers

	assign load_word = flash_mem[pointer[PAGE_MSB:WORD_LSB]];

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			O_LOAD_VALID <= 1'b0;
			O_LOAD_DATA <= RESET_BYTE;
		end else begin
			O_LOAD_VALID <= I_LOAD_STROBE && cpu_active;
			if (load_fuse) begin
				if (pointer == PTR_LOW_FUSE) begin
					O_LOAD_DATA <= I_LOW_FUSE;
				end else if (pointer == PTR_LOCK) begin
					O_LOAD_DATA <= I_LOCK_BITS;
				end else if (pointer == PTR_HIGH_FUSE) begin
					O_LOAD_DATA <= I_HIGH_FUSE;
				end else begin
					// unlisted pointer in fuse mode answers all ones
					O_LOAD_DATA <= ERASED_BYTE;
				end
			end else if (I_LOAD_STROBE && cpu_active) begin
				O_LOAD_DATA <= pointer[0] ? load_word[15:8] :
					load_word[7:0];
			end
		end
	end

endmodule // flash_self_program_control

/* core/flash_self_program_pkg.sv */
// constants and types for the flash self-programming controller
package flash_self_program_pkg;

	// register byte offsets on the register bus
	localparam logic [7:0] OFFS_CONTROL_STATUS = 8'h00;
	localparam logic [7:0] OFFS_POINTER_HIGH = 8'h04;
	localparam logic [7:0] OFFS_POINTER_LOW = 8'h08;
	localparam logic [7:0] OFFS_ENGINE_STATUS = 8'h0C;

	// control/status field positions
	localparam int BIT_ENABLE = 0;
	localparam int BIT_PAGE_ERASE = 1;
	localparam int BIT_PAGE_WRITE = 2;
	localparam int BIT_FUSE_READ = 3;
	localparam int BIT_BUFFER_CLEAR = 4;

	// accepted low five bit command patterns, and the idle value CMD_NONE
	localparam logic [4:0] CMD_BUFFER_CLEAR = 5'h11;
	localparam logic [4:0] CMD_FUSE_READ = 5'h09;
	localparam logic [4:0] CMD_PAGE_WRITE = 5'h05;
	localparam logic [4:0] CMD_PAGE_ERASE = 5'h03;
	localparam logic [4:0] CMD_BUFFER_LOAD = 5'h01;
	localparam logic [4:0] CMD_NONE = 5'h00;

	// arming windows in clock cycles
	localparam logic [2:0] STORE_WINDOW = 3'h4;
	localparam logic [2:0] LOAD_WINDOW = 3'h3;

	// flash geometry: 512 words, pages of 16 words
	localparam int WORD_LSB = 1;
	localparam int WORD_MSB = 4;
	localparam int PAGE_LSB = 5;
	localparam int PAGE_MSB = 9;
	localparam int FLASH_WORDS = 512;
	localparam int PAGE_WORDS = 16;

	// fuse/lock pointer values
	localparam logic [15:0] PTR_LOW_FUSE = 16'h0000;
	localparam logic [15:0] PTR_LOCK = 16'h0001;
	localparam logic [15:0] PTR_HIGH_FUSE = 16'h0003;

	// reset and erased values
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [15:0] ERASED_WORD = 16'hFFFF;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;

	// flash write time
	localparam int CLK_FREQ_MHZ = 200;
	localparam int PROG_MIN_TIME_NS = 3700000;
	localparam int PROG_MAX_TIME_NS = 4500000;
	localparam int PROG_CYCLES_DEFAULT =
		(PROG_MIN_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;

	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		OP_IDLE = 2'b00,
		OP_ERASE = 2'b01,
		OP_WRITE = 2'b10
	} flash_op_t;

endpackage

/* tb/cpu_model.sv */
// cpu core model issuing program memory strobes
`timescale 1ns/10ps
module cpu_model (
	input wire logic i_halt,
	input wire logic i_rogue,
	input wire logic i_st,
	input wire logic i_ld,
	output logic o_st,
	output logic o_ld
);
	// a stalled core issues nothing unless told to misbehave
	assign o_st = i_st && (!i_halt || i_rogue);
	assign o_ld = i_ld && (!i_halt || i_rogue);
endmodule // cpu_model

/* tb/flash_self_program_props.sv */
// assertions on the flash self-programming controller ports
`timescale 1ns/10ps
module flash_self_program_props
	import flash_self_program_pkg::*;
#(
	parameter int PROG_CYCLES = 20
) (
	input wire logic I_CLK,
	input wire logic I_RST,
	input wire logic [31:0] I_ARADDR,
	input wire logic I_ARVALID,
	input wire logic O_ARREADY,
	input wire logic [31:0] O_RDATA,
	input wire logic O_RVALID,
	input wire logic I_RREADY,
	input wire logic O_BVALID,
	input wire logic I_BREADY,
	input wire logic I_STORE_STROBE,
	input wire logic I_LOAD_STROBE,
	input wire logic O_LOAD_VALID,
	input wire logic O_CPU_HALT
);
	logic [7:0] ra;
	int hcnt;
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (I_RST);
	always_ff @(posedge I_CLK) begin
		if (I_ARVALID && O_ARREADY) ra <= I_ARADDR[7:0];
	end
	// halt length counter
	always_ff @(posedge I_CLK) begin
		if (!O_CPU_HALT) hcnt <= 0;
		else hcnt <= hcnt + 1;
	end
	////////////////////////////////////////
	property p_rsv;
		O_RVALID && ra == OFFS_CONTROL_STATUS |-> O_RDATA[7:5] == 3'h0;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bits set");
	property p_ld;
		I_LOAD_STROBE && !O_CPU_HALT |=> O_LOAD_VALID;
	endproperty
	a_ld: assert property (p_ld) else $error("load not answered");
	property p_ldsrc;
		O_LOAD_VALID |-> $past(I_LOAD_STROBE) && !$past(O_CPU_HALT);
	endproperty
	a_ldsrc: assert property (p_ldsrc) else $error("stray load");
	property p_hrefuse;
		I_LOAD_STROBE && O_CPU_HALT |=> !O_LOAD_VALID;
	endproperty
	a_hrefuse: assert property (p_hrefuse) else $error("load in halt");
	property p_hcause;
		$rose(O_CPU_HALT) |-> $past(I_STORE_STROBE);
	endproperty
	a_hcause: assert property (p_hcause) else $error("halt w/o store");
	property p_hlen;
		$fell(O_CPU_HALT) |-> hcnt == PROG_CYCLES;
	endproperty
	a_hlen: assert property (p_hlen) else $error("halt length");
	property p_bhold;
		O_BVALID && !I_BREADY |=> O_BVALID;
	endproperty
	a_bhold: assert property (p_bhold) else $error("bvalid dropped");
	property p_rhold;
		O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA);
	endproperty
	a_rhold: assert property (p_rhold) else $error("rvalid dropped");
endmodule // flash_self_program_props

bind flash_self_program_control flash_self_program_props #(
	.PROG_CYCLES(PROG_CYCLES)
) props_inst (
	.I_CLK(I_CLK), .I_RST(I_RST), .I_ARADDR(I_ARADDR),
	.I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY), .O_RDATA(O_RDATA),
	.O_RVALID(O_RVALID), .I_RREADY(I_RREADY), .O_BVALID(O_BVALID),
	.I_BREADY(I_BREADY), .I_STORE_STROBE(I_STORE_STROBE),
	.I_LOAD_STROBE(I_LOAD_STROBE), .O_LOAD_VALID(O_LOAD_VALID),
	.O_CPU_HALT(O_CPU_HALT)
);

/* tb/tb_top.sv */
// self-checking bench for the flash self-programming controller
`timescale 1ns/10ps
module tb_top
	import flash_self_program_pkg::*;
;
	localparam int PC = 20;
	logic clk = 0, rst = 1, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
	logic st = 0, ld = 0, eeb = 0, rogue = 0, sst, sld;
	logic awr, wrd, bv, arr, rv, lv, hv, halt, lval;
	logic [31:0] awa = 0, wd = 0, ara = 0, rdat;
	logic [15:0] pair = 0, p, d, e;
	logic [7:0] lf = 0, hf = 0, lk = 0, ldat, lb, b;
	logic [1:0] bresp, rresp, r;
	int error_cnt = 0, n_compared = 0;
	always #2.5 clk = ~clk;
	flash_self_program_control #(
		.PROG_CYCLES(PC)
	) flash_self_program_control_inst (
		.I_CLK(clk), .I_RST(rst), .I_AWADDR(awa), .I_AWVALID(awv),
		.O_AWREADY(awr), .I_WDATA(wd), .I_WSTRB(4'hF), .I_WVALID(wv),
		.O_WREADY(wrd), .O_BRESP(bresp), .O_BVALID(bv), .I_BREADY(br),
		.I_ARADDR(ara), .I_ARVALID(arv), .O_ARREADY(arr), .O_RDATA(rdat),
		.O_RRESP(rresp), .O_RVALID(rv), .I_RREADY(rr),
		.I_STORE_STROBE(sst), .I_LOAD_STROBE(sld), .I_DATA_PAIR(pair),
		.O_LOAD_DATA(ldat), .O_LOAD_VALID(lval), .O_CPU_HALT(halt),
		.I_EEPROM_WRITE_BUSY(eeb), .I_LOW_FUSE(lf), .I_HIGH_FUSE(hf),
		.I_LOCK_BITS(lk)
	);
	cpu_model cpu_model_inst (.i_halt(halt), .i_rogue(rogue), .i_st(st),
		.i_ld(ld), .o_st(sst), .o_ld(sld));
	////////////////////////////////////////
	task automatic give_verdict();
		$display("compared %0d errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(string n, logic [15:0] x, logic [15:0] s);
		n_compared++;
		if (s !== x) begin
			error_cnt++;
			$display("MISMATCH %s exp %h got %h", n, x, s);
		end
	endtask
	task automatic lim(int k);
		if (k >= 60) begin
			error_cnt++;
			give_verdict();
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] v);
		int k;
		awa <= {24'h0, a};
		wd <= {24'h0, v};
		awv <= 1'h1;
		wv <= 1'h1;
		br <= 1'h1;
		for (k = 0; k < 60; k++) begin
			@(posedge clk);
			if (awr) awv <= 1'h0;
			if (wrd) wv <= 1'h0;
			if (bv) break;
		end
		r = bresp;
		lim(k);
	endtask
	task automatic rd(logic [7:0] a);
		int k;
		ara <= {24'h0, a};
		arv <= 1'h1;
		rr <= 1'h1;
		for (k = 0; k < 60; k++) begin
			@(posedge clk);
			if (arr) arv <= 1'h0;
			if (rv) break;
		end
		b = rdat[7:0];
		r = rresp;
		rr <= 1'h0;
		lim(k);
	endtask
	task automatic cpu(logic s);
		st <= s;
		ld <= !s;
		@(posedge clk);
		st <= 1'h0;
		ld <= 1'h0;
		#1;
		lv = lval;
		lb = ldat;
		hv = halt;
		@(posedge clk);
	endtask
	task automatic idle();
		int k;
		for (k = 0; k < 60 && halt; k++) @(posedge clk);
		lim(k);
	endtask
	task automatic setp(logic [15:0] v);
		wr(OFFS_POINTER_HIGH, v[15:8]);
		wr(OFFS_POINTER_LOW, v[7:0]);
	endtask
	task automatic prog();
		int j;
		for (j = 0; j < 2; j++) begin
			wr(OFFS_CONTROL_STATUS, j ? 8'(CMD_PAGE_WRITE) : 8'(CMD_PAGE_ERASE));
			cpu(1'h1);
			chk("halt", 16'h1, 16'(hv));
			rogue <= 1'h1;
			cpu(1'h0);
			rogue <= 1'h0;
			chk("lvalid", 16'h0, 16'(lv));
			idle();
			rd(OFFS_CONTROL_STATUS);
			chk("ctrl", 16'h0, 16'(b));
		end
	endtask
	function automatic logic [7:0] fuse_exp(logic [15:0] v);
		case (v)
			PTR_LOW_FUSE: return lf;
			PTR_LOCK: return lk;
			PTR_HIGH_FUSE: return hf;
			default: return ERASED_BYTE;
		endcase
	endfunction
	////////////////////////////////////////
	initial begin
		int i, m;
		void'($urandom(6056));
		lf = 8'($urandom);
		hf = 8'($urandom);
		lk = 8'($urandom);
		repeat (4) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		rd(8'h10);
		chk("resp", 16'(RESP_SLVERR), 16'(r));
		wr(8'h10, 8'hFF);
		chk("bresp", 16'(RESP_SLVERR), 16'(r));
		wr(OFFS_POINTER_LOW, 8'h00);
		chk("bresp", 16'(RESP_OKAY), 16'(r));
		for (i = 0; i < 4; i++) begin
			setp(16'(i ^ (i >> 1)));
			wr(OFFS_CONTROL_STATUS, 8'(CMD_FUSE_READ));
			cpu(1'h0);
			chk("fuse", 16'(fuse_exp(16'(i ^ (i >> 1)))), 16'(lb));
		end
		wr(OFFS_CONTROL_STATUS, 8'hFF);
		rd(OFFS_CONTROL_STATUS);
		chk("rsv", 16'h0, 16'(b));
		for (i = 0; i < 2; i++) begin
			wr(OFFS_CONTROL_STATUS, i ? 8'(CMD_PAGE_WRITE) : 8'(CMD_FUSE_READ));
			repeat (5) @(posedge clk);
			rd(OFFS_CONTROL_STATUS);
			chk("ctrl", 16'h0, 16'(b));
			cpu(1'h1);
			chk("halt", 16'h0, 16'(hv));
		end
		for (i = 0; i < 2; i++) begin
			if (i == 0) eeb <= 1'h1;
			wr(OFFS_CONTROL_STATUS, 8'(CMD_PAGE_ERASE));
			eeb <= 1'h1;
			cpu(1'h1);
			chk("halt", 16'h0, 16'(hv));
			eeb <= 1'h0;
		end
		for (m = 0; m < 3; m++) begin
			p = {6'h0, 5'($urandom), 4'($urandom), 1'h0};
			d = 16'($urandom);
			pair <= d;
			setp(p | 16'h1);
			wr(OFFS_CONTROL_STATUS, 8'(CMD_BUFFER_LOAD));
			cpu(1'h1);
			chk("halt", 16'h0, 16'(hv));
			if (m == 1) wr(OFFS_CONTROL_STATUS, 8'(CMD_BUFFER_CLEAR));
			if (m == 2) eeb <= 1'h1;
			@(posedge clk);
			eeb <= 1'h0;
			prog();
			e = m ? ERASED_WORD : d;
			for (i = 0; i < 2; i++) begin
				setp(p | 16'(i));
				cpu(1'h0);
				chk("byte", 16'(8'(e >> (8 * i))), 16'(lb));
			end
		end
		setp(16'h0);
		pair <= 16'h5A5A;
		wr(OFFS_CONTROL_STATUS, 8'(CMD_BUFFER_LOAD));
		cpu(1'h1);
		wr(OFFS_CONTROL_STATUS, 8'(CMD_PAGE_ERASE));
		cpu(1'h1);
		rst <= 1'h1;
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		chk("halt", 16'h1, 16'(halt));
		rd(OFFS_ENGINE_STATUS);
		chk("engine", 16'(OP_ERASE), 16'(b));
		idle();
		prog();
		cpu(1'h0);
		chk("byte", 16'(ERASED_BYTE), 16'(lb));
		give_verdict();
	end
endmodule // tb_top
